// ===== shared/drc_consts.svh
// Register offsets, field positions, reset values and widths of the reference converter.
`ifndef DRC_CONSTS_SVH
`define DRC_CONSTS_SVH

`define DRC_ADDR_W       4
`define DRC_OFF_CONTROL  4'h0
`define DRC_OFF_LEVEL    4'h4
`define DRC_BIT_ON       7
`define DRC_BIT_PIN_EN   5
`define DRC_SRC_HI       3
`define DRC_SRC_LO       2
`define DRC_CODE_W       5
`define DRC_LEVEL_W      16
`define DRC_CONTROL_MASK 8'hac
`define DRC_LEVEL_MASK   8'h1f
`define DRC_RESET_VAL    8'h00
`define DRC_UNMAPPED     32'h00000000

`endif

// ===== shared/drc_pkg.sv
// Types shared by the reference converter control logic.
package drc_pkg;
   typedef enum logic [1:0] {
      DRC_SRC_SUPPLY,
      DRC_SRC_EXT_PIN,
      DRC_SRC_FIXED_REF,
      DRC_SRC_RESERVED
   } drc_src_type;
endpackage

// ===== core/drc_ref_control.sv
// Reference converter control: registers, source routing and pin override.
//
// Function
// - Converter runs only while dac_on, bit 7 of dac_control, is one.
// - Five-bit level_code in low bits of dac_level gives 32 levels.
// - Enabled output is lower_ref plus span times level_code over 32.
// - pos_source_sel picks supply, external pin, fixed_ref; code 11 reserved.
// - lower_ref is always ground; nothing selects it.
// - ladder_out goes to comparator, ADC channel and ref_out_pin.
// - ref_pin_drive_en routes level to pin, kills driver, pull-up, input.
// - Port read of ref_out_pin returns zero while carrying the reference.
// - Sleep wake-up leaves dac_control untouched.
// - Any reset disables converter, frees pin, clears all control bits.
// - Unimplemented bits read zero and ignore writes.
`timescale 1ns/1ns
`include "drc_consts.svh"

module drc_ref_control
   import drc_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic [`DRC_ADDR_W-1:0]  avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [31:0]             avs_writedata,
   input  wire logic [3:0]              avs_byteenable,
   output logic      [31:0]             avs_readdata,
   output logic                         avs_waitrequest,
   input  wire logic [`DRC_LEVEL_W-1:0] supply_level,
   input  wire logic [`DRC_LEVEL_W-1:0] ext_ref_level,
   input  wire logic [`DRC_LEVEL_W-1:0] fixed_ref_level,
   input  wire logic                    pin_digital_in,
   output logic      [`DRC_LEVEL_W-1:0] ladder_out,
   output logic      [`DRC_LEVEL_W-1:0] cmp_pos_ref,
   output logic      [`DRC_LEVEL_W-1:0] adc_ref_chan,
   output logic      [`DRC_LEVEL_W-1:0] ref_out_pin_level,
   output logic                         ref_out_pin_connect,
   output logic                         pin_driver_off,
   output logic                         pin_pullup_off,
   output logic                         pin_input_off,
   output logic                         pin_port_read,
   output logic                         dac_on,
   output logic [1:0]                   pos_source_sel,
   output logic [`DRC_CODE_W-1:0]       level_code
);

   // Stored control bits; only implemented positions are ever set.
   logic [7:0] control_ff;
   logic [7:0] nxt_control;
   logic [7:0] level_ff;
   logic [7:0] nxt_level;
   logic       ack_ff;
   logic       pin_sync1_ff;
   logic       pin_sync2_ff;
   logic [`DRC_LEVEL_W-1:0] ladder_ff;
   logic [`DRC_LEVEL_W-1:0] nxt_ladder;

   // Decode of a register access to a given offset.
   function automatic logic hit(input logic [`DRC_ADDR_W-1:0] a,
                                input logic [`DRC_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // Each access is answered one cycle after it is first seen; waitrequest
   // is high while the request is pending so the master holds it stable.
   wire access  = avs_read | avs_write;
   wire take    = access & ack_ff;
   wire wr_ctl  = take & avs_write & avs_byteenable[0]
                  & hit(avs_address, `DRC_OFF_CONTROL);
   wire wr_lvl  = take & avs_write & avs_byteenable[0]
                  & hit(avs_address, `DRC_OFF_LEVEL);
   wire rd_ctl  = hit(avs_address, `DRC_OFF_CONTROL);
   wire rd_lvl  = hit(avs_address, `DRC_OFF_LEVEL);
   assign avs_waitrequest = access & ~ack_ff;

   // Masks drop unimplemented bits so they read zero and ignore writes.
   assign nxt_control = wr_ctl ? (avs_writedata[7:0] & `DRC_CONTROL_MASK)
                               : control_ff;
   assign nxt_level   = wr_lvl ? (avs_writedata[7:0] & `DRC_LEVEL_MASK)
                               : level_ff;

   // Bus handshake and register storage; reset clears every control bit.
   always_ff @(posedge clk) begin
      if (rst) begin
         control_ff <= `DRC_RESET_VAL;
         level_ff   <= `DRC_RESET_VAL;
         ack_ff     <= 1'b0;
      end else begin
         control_ff <= nxt_control;
         level_ff   <= nxt_level;
         ack_ff     <= access & ~ack_ff;
      end
   end

   // Read data is registered during the wait cycle so it is stable at take.
   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read & ~ack_ff) begin
         avs_readdata <= rd_ctl ? {24'h000000, control_ff} :
                         rd_lvl ? {24'h000000, level_ff} :
                         `DRC_UNMAPPED;
      end
   end

   // Field views of the stored registers.
   assign dac_on         = control_ff[`DRC_BIT_ON];
   assign pos_source_sel = control_ff[`DRC_SRC_HI:`DRC_SRC_LO];
   assign level_code     = level_ff[`DRC_CODE_W-1:0];
   wire   pin_en         = control_ff[`DRC_BIT_PIN_EN];

   // Upper reference mux; the reserved code yields ground rather than a
   // guess, so a stray write cannot drive an unexpected level.
   logic [`DRC_LEVEL_W-1:0] upper_ref;
   always_comb begin
      case (drc_src_type'(pos_source_sel))
         DRC_SRC_SUPPLY:    upper_ref = supply_level;
         DRC_SRC_EXT_PIN:   upper_ref = ext_ref_level;
         DRC_SRC_FIXED_REF: upper_ref = fixed_ref_level;
         default:           upper_ref = '0;
      endcase
   end

   // Ladder model. lower_ref is ground, so the span is upper_ref itself.
   wire [`DRC_LEVEL_W-1:0] lower_ref = '0;
   wire [`DRC_LEVEL_W+4:0] scaled = (upper_ref - lower_ref) * level_code;
   assign nxt_ladder = dac_on
                       ? (scaled[`DRC_LEVEL_W+4:`DRC_CODE_W] + lower_ref)
                       : '0;

   // Registered so data outputs come from flip-flops.
   always_ff @(posedge clk) begin
      if (rst) begin
         ladder_ff <= '0;
      end else begin
         ladder_ff <= nxt_ladder;
      end
   end

   // Distribution of the level to its consumers.
   assign ladder_out        = ladder_ff;
   assign cmp_pos_ref       = ladder_ff;
   assign adc_ref_chan      = ladder_ff;
   assign ref_out_pin_level = pin_en ? ladder_ff : '0;
   assign ref_out_pin_connect = pin_en;
   assign pin_driver_off    = pin_en;
   assign pin_pullup_off    = pin_en;
   assign pin_input_off     = pin_en;

   // The pin level is asynchronous, so it passes two flops before use.
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_sync1_ff <= 1'b0;
         pin_sync2_ff <= 1'b0;
      end else begin
         pin_sync1_ff <= pin_digital_in;
         pin_sync2_ff <= pin_sync1_ff;
      end
   end
   assign pin_port_read = pin_en ? 1'b0 : pin_sync2_ff;

   // Level writes: the take of a write aimed at the level offset.
   sequence s_level_write;
      wr_lvl;
   endsequence

   // A write takes effect on the edge after its take and nowhere else.
   a_level_write_lands: assert property (
      @(posedge clk) disable iff (rst)
      s_level_write |=> level_code == $past(avs_writedata[4:0]))
      else $error("level code did not take the written value");

   // Control writes are built from the two bus steps: wait, then take.
   sequence s_ctl_wait;
      avs_write && avs_waitrequest && hit(avs_address, `DRC_OFF_CONTROL);
   endsequence

   sequence s_ctl_take;
      avs_write && !avs_waitrequest && avs_byteenable[0]
         && hit(avs_address, `DRC_OFF_CONTROL);
   endsequence

   // The stored control byte is the written byte with the holes masked.
   a_control_write_lands: assert property (
      @(posedge clk) disable iff (rst)
      s_ctl_wait ##1 s_ctl_take |=>
      control_ff == ($past(avs_writedata[7:0]) & `DRC_CONTROL_MASK))
      else $error("control register did not take the written value");

   // Holes in the control byte must never hold a one.
   a_control_unimpl_zero: assert property (
      @(posedge clk) disable iff (rst)
      (control_ff & 8'h53) == 8'h00)
      else $error("unimplemented control bits are set");

   // Holes in the level byte must never hold a one.
   a_level_unimpl_zero: assert property (
      @(posedge clk) disable iff (rst)
      level_ff[7:5] == 3'h0)
      else $error("unimplemented level bits are set");

   // While off, the ladder carries nothing, one register stage later.
   a_off_means_zero: assert property (
      @(posedge clk) disable iff (rst)
      !$past(dac_on) |-> ladder_out == '0)
      else $error("ladder output present while off");

   // Supply source. The product is widened first, since a product held
   // to the level width would lose its top bits before the shift.
   a_ladder_value: assert property (
      @(posedge clk) disable iff (rst)
      $past(dac_on) && $past(pos_source_sel) == 2'b00 |->
      ladder_out == (({5'h00, $past(supply_level)}
                      * $past(level_code)) >> 5))
      else $error("ladder level does not match code");

   // The external pin source scales the same way.
   a_ladder_ext: assert property (
      @(posedge clk) disable iff (rst)
      $past(dac_on) && $past(pos_source_sel) == 2'b01 |->
      ladder_out == (({5'h00, $past(ext_ref_level)}
                      * $past(level_code)) >> 5))
      else $error("ladder level wrong for the external source");

   // The fixed reference source scales the same way.
   a_ladder_fixed: assert property (
      @(posedge clk) disable iff (rst)
      $past(dac_on) && $past(pos_source_sel) == 2'b10 |->
      ladder_out == (({5'h00, $past(fixed_ref_level)}
                      * $past(level_code)) >> 5))
      else $error("ladder level wrong for the fixed source");

   // The reserved code must not put any level out, so a stray write
   // to the source field stays harmless.
   a_reserved_ground: assert property (
      @(posedge clk) disable iff (rst)
      $past(pos_source_sel) == 2'b11 |-> ladder_out == '0)
      else $error("reserved source gave nonzero level");

   // The lower end is ground: a zero code gives zero for any source.
   a_zero_code_ground: assert property (
      @(posedge clk) disable iff (rst)
      $past(level_code) == 5'h00 |-> ladder_out == '0)
      else $error("zero code gave a level above ground");

   // Comparator and converter channel see the same level.
   a_copies_agree: assert property (
      @(posedge clk) disable iff (rst)
      cmp_pos_ref == ladder_out && adc_ref_chan == ladder_out)
      else $error("level consumers disagree");

   // With the pin carrying the level, every digital function is off.
   a_pin_override: assert property (
      @(posedge clk) disable iff (rst)
      pin_en |-> pin_driver_off && pin_pullup_off && pin_input_off
             && !pin_port_read && ref_out_pin_level == ladder_out)
      else $error("pin override incomplete");

   // Without the enable the pin is let go.
   a_pin_released: assert property (
      @(posedge clk) disable iff (rst)
      !pin_en |-> ref_out_pin_level == '0 && !ref_out_pin_connect)
      else $error("level left on pin while disabled");

   // An off converter leaves nothing on the pin either.
   a_pin_zero_off: assert property (
      @(posedge clk) disable iff (rst)
      !$past(dac_on) |-> ref_out_pin_level == '0)
      else $error("pin carries a level while off");

   // A free pin reads back through the synchroniser, two edges late;
   // edges right after reset are skipped while the flops refill.
   a_port_follows_pin: assert property (
      @(posedge clk) disable iff (rst)
      !pin_en && !$past(rst) && !$past(rst, 2) |->
      pin_port_read == $past(pin_digital_in, 2))
      else $error("port read does not follow the free pin");

   // Reset clears every stored bit and the level.
   a_reset_clears: assert property (
      @(posedge clk)
      rst |=> control_ff == 8'h00 && level_ff == 8'h00
              && ladder_out == '0)
      else $error("reset did not clear control state");

   // Reset also stops the converter and frees the pin.
   a_reset_pin_free: assert property (
      @(posedge clk)
      rst |=> !ref_out_pin_connect && !dac_on && level_code == 5'h00
              && ref_out_pin_level == '0)
      else $error("reset left the converter running");

   // Nothing but a write changes the control byte, so a wake-up from
   // sleep finds it as it was left.
   a_control_holds: assert property (
      @(posedge clk) disable iff (rst)
      !wr_ctl |=> $stable(control_ff))
      else $error("control register changed without a write");

   // The level byte likewise only moves on its own write.
   a_level_holds: assert property (
      @(posedge clk) disable iff (rst)
      !wr_lvl |=> $stable(level_ff))
      else $error("level register changed without a write");

   // A pending request waits exactly one cycle before its answer;
   // the master holds it meanwhile.
   sequence s_request_waits;
      access && avs_waitrequest;
   endsequence

   a_bus_answers: assert property (
      @(posedge clk) disable iff (rst)
      s_request_waits |=> !avs_waitrequest)
      else $error("bus answer late");

   // A fresh request is never answered in its first cycle.
   a_first_cycle_waits: assert property (
      @(posedge clk) disable iff (rst)
      $rose(access) |-> avs_waitrequest)
      else $error("request answered without a wait cycle");

   // A control read returns the stored byte with zero upper lanes.
   a_read_control: assert property (
      @(posedge clk) disable iff (rst)
      take && avs_read && rd_ctl |->
      avs_readdata == {24'h000000, control_ff})
      else $error("control read returned a wrong value");

   // A level read returns the stored byte with zero upper lanes.
   a_read_level: assert property (
      @(posedge clk) disable iff (rst)
      take && avs_read && rd_lvl |->
      avs_readdata == {24'h000000, level_ff})
      else $error("level read returned a wrong value");

   // A read of an unmapped offset returns zero.
   a_read_unmapped: assert property (
      @(posedge clk) disable iff (rst)
      take && avs_read && !rd_ctl && !rd_lvl |->
      avs_readdata == `DRC_UNMAPPED)
      else $error("unmapped read returned nonzero data");

endmodule

// ===== tb/tb_dac_reference_control.sv
// Self-checking bench for the reference converter control block.
`timescale 1ns/1ns
`include "drc_consts.svh"

// Counts a comparison and reports a miss on one line.
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
   fail_count++; $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end

module tb_dac_reference_control;
   logic        clk, rst, avs_read, avs_write, pin_digital_in, avs_waitrequest;
   logic [3:0]  avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [15:0] supply_level, ext_ref_level, fixed_ref_level, ladder_out;
   logic [15:0] cmp_pos_ref, adc_ref_chan, ref_out_pin_level, ex;
   logic        ref_out_pin_connect, pin_driver_off, pin_pullup_off;
   logic        pin_input_off, pin_port_read, dac_on, be0;
   logic [1:0]  pos_source_sel;
   logic [4:0]  level_code;
   logic [7:0]  ctl, lvl, wc, wl;
   int          fail_count, tests_run;

   drc_ref_control u_drc_ref_control (.clk(clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .supply_level(supply_level),
      .ext_ref_level(ext_ref_level), .fixed_ref_level(fixed_ref_level),
      .pin_digital_in(pin_digital_in), .ladder_out(ladder_out),
      .cmp_pos_ref(cmp_pos_ref), .adc_ref_chan(adc_ref_chan),
      .ref_out_pin_level(ref_out_pin_level),
      .ref_out_pin_connect(ref_out_pin_connect),
      .pin_driver_off(pin_driver_off), .pin_pullup_off(pin_pullup_off),
      .pin_input_off(pin_input_off), .pin_port_read(pin_port_read),
      .dac_on(dac_on), .pos_source_sel(pos_source_sel),
      .level_code(level_code));

   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   // Prints the counts and the verdict, then stops the run.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One bus access; holds the request until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [3:0] ad,
                      input logic [7:0] wd, input logic b0);
      int n;
      n = 0;
      @(posedge clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= ad;
      avs_writedata <= {24'h0, wd};
      avs_byteenable <= {3'b101, b0};
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) fail_count++;
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // Level the ladder should settle to for the given register contents.
   function automatic logic [15:0] expect_level(input logic [7:0] c,
                                                input logic [4:0] k);
      logic [15:0] up;
      logic [20:0] prod;
      case (c[3:2])
         2'b00: up = supply_level;
         2'b01: up = ext_ref_level;
         2'b10: up = fixed_ref_level;
         default: up = 16'h0;
      endcase
      prod = up * k;
      return c[7] ? prod[20:5] : 16'h0;
   endfunction

   // Fields half a cycle after the take edge, routed levels a cycle later.
   task automatic check_all();
      @(negedge clk);
      `CHK("dac_on", ctl[7], dac_on)
      `CHK("source", ctl[3:2], pos_source_sel)
      `CHK("code", lvl[4:0], level_code)
      @(negedge clk);
      ex = expect_level(ctl, lvl[4:0]);
      `CHK("ladder", ex, ladder_out)
      `CHK("cmp", ex, cmp_pos_ref)
      `CHK("adc", ex, adc_ref_chan)
      `CHK("pin level", ctl[5] ? ex : 16'h0, ref_out_pin_level)
      `CHK("override", {4{ctl[5]}}, {ref_out_pin_connect, pin_driver_off,
           pin_pullup_off, pin_input_off})
      `CHK("port", ctl[5] ? 1'b0 : pin_digital_in, pin_port_read)
      bus(1'b0, `DRC_OFF_CONTROL, 8'h0, 1'b1);
      `CHK("rd control", {24'h0, ctl}, rd)
      bus(1'b0, `DRC_OFF_LEVEL, 8'h0, 1'b1);
      `CHK("rd level", {24'h0, lvl}, rd)
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      end_of_test();
   end

   // Main sequence: reset, source sweep, random writes, corner cases.
   initial begin
      clk = 0; rst = 1; avs_read = 0; avs_write = 0; avs_address = 0;
      avs_writedata = 0; avs_byteenable = 0; pin_digital_in = 0;
      supply_level = 16'hffff; ext_ref_level = 0; fixed_ref_level = 0;
      fail_count = 0; tests_run = 0; ctl = 0; lvl = 0;
      void'($urandom(32'hcb030769));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      check_all();
      for (int i = 0; i < 40; i++) begin
         // The first four pass every source code at full scale.
         wc = (i < 4) ? {4'hf, i[1:0], 2'b11} : 8'($urandom);
         wl = (i < 4) ? 8'hff : 8'($urandom);
         be0 = (i < 4) ? 1'b1 : ($urandom % 4 != 0);
         ext_ref_level <= 16'($urandom);
         fixed_ref_level <= 16'($urandom);
         if (i >= 4) supply_level <= 16'($urandom);
         pin_digital_in <= 1'($urandom);
         bus(1'b1, `DRC_OFF_CONTROL, wc, be0);
         bus(1'b1, `DRC_OFF_LEVEL, wl, be0);
         if (be0) ctl = wc & `DRC_CONTROL_MASK;
         if (be0) lvl = wl & `DRC_LEVEL_MASK;
         check_all();
      end
      // Unmapped place reads zero and a write there changes nothing.
      bus(1'b1, 4'h8, 8'hff, 1'b1);
      bus(1'b0, 4'h8, 8'h0, 1'b1);
      `CHK("unmapped", 32'h0, rd)
      repeat (20) @(posedge clk);
      check_all();
      // Reset in mid-run after setting every implemented bit.
      bus(1'b1, `DRC_OFF_CONTROL, 8'hff, 1'b1);
      bus(1'b1, `DRC_OFF_LEVEL, 8'hff, 1'b1);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // Let the pin synchroniser refill before the port read is checked.
      repeat (2) @(posedge clk);
      ctl = 0;
      lvl = 0;
      check_all();
      end_of_test();
   end
endmodule
